// File: srb_pkg.sv
package srb_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int COL_W    = 8;
	localparam int BANK_W   = 2;
	localparam int DATA_W   = 16;
	localparam int NBANK    = 4;
	localparam int LAT_MAX  = 3;

	// ----------------------------------------
	// Register map (byte offsets are indices)
	// ----------------------------------------
	localparam logic [3:0] REG_MODE_OFS   = 4'h0;
	localparam logic [3:0] REG_STATUS_OFS = 4'h1;
	localparam logic [3:0] REG_ROWS_OFS   = 4'h2;

	// Mode field positions
	localparam int MODE_BL_LSB  = 0;
	localparam int MODE_CL_LSB  = 4;

	// Reset values
	localparam logic [2:0] BL_RST = 3'h2;
	localparam logic [1:0] CL_RST = 2'h3;

	// Burst length codes
	localparam logic [2:0] BL_ONE   = 3'h0;
	localparam logic [2:0] BL_TWO   = 3'h1;
	localparam logic [2:0] BL_FOUR  = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_PAGE  = 3'h7;

	// ----------------------------------------
	// Commands
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRB_CMD_NOP   = 3'h0,
		SRB_CMD_ACT   = 3'h1,
		SRB_CMD_READ  = 3'h2,
		SRB_CMD_WRITE = 3'h3,
		SRB_CMD_PRE   = 3'h4,
		SRB_CMD_TERM  = 3'h5
	} srb_cmd_t;

	typedef struct packed {
		srb_cmd_t            cmd;
		logic [BANK_W-1:0]   bank;
		logic [COL_W-1:0]    col;
		logic                auto_pre;
		logic                all_banks;
	} srb_req_t;

	typedef enum logic [1:0] {
		SRB_IDLE = 2'b00,
		SRB_RUN  = 2'b01
	} srb_state_t;

endpackage

// File: srb_read_burst.sv
// Function
// - Read takes bank, start column and auto-precharge choice for that burst alone.
// - Auto-precharge read closes its row once the burst completes.
// - First element appears read latency clocks after read, then one per clock.
// - Data pins released once final element delivered.
// - Full-page burst runs until ended, column wraps to zero.
// - New read interrupts or follows burst with no gap between elements.
// - A read is accepted on every clock, any bank.
// - After truncating write, pins stay released if mask was high before it.
// - Timely row close after completed burst equals auto-precharge result.
// - Burst lengths one, two, four, eight, full page; longer bursts interruptible.
// - Burst terminate stops the burst only; row stays open.
`timescale 1ns/1ps
`default_nettype none

module srb_read_burst
	import srb_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Command pins (registered here)
	input  wire srb_req_t          req_pin,
	input  wire logic              out_mask_pin,
	// Data pins
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe,
	// Array read port
	output logic [BANK_W-1:0]      arr_bank,
	output logic [COL_W-1:0]       arr_col,
	input  wire logic [DATA_W-1:0] arr_data,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// Status
	output logic [NBANK-1:0]       row_open
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	srb_req_t req_s1_r;
	srb_req_t req_r;
	logic     mask_s1_r;
	logic     mask_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_s1_r  <= '0;
			req_r     <= '0;
			mask_s1_r <= 1'b0;
			mask_r    <= 1'b0;
		end else begin
			req_s1_r  <= req_pin;
			req_r     <= req_s1_r;
			mask_s1_r <= out_mask_pin;
			mask_r    <= mask_s1_r;
		end
	end

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	logic [2:0] bl_r;
	logic [1:0] cl_r;

	wire wr_mode = reg_wr && (reg_addr == REG_MODE_OFS);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bl_r <= BL_RST;
			cl_r <= CL_RST;
		end else if (wr_mode) begin
			bl_r <= reg_wdata[MODE_BL_LSB +: 3];
			cl_r <= (reg_wdata[MODE_CL_LSB +: 2] == 2'h2) ? 2'h2 : 2'h3;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire is_read  = (req_r.cmd == SRB_CMD_READ);
	wire is_write = (req_r.cmd == SRB_CMD_WRITE);
	wire is_pre   = (req_r.cmd == SRB_CMD_PRE);
	wire is_term  = (req_r.cmd == SRB_CMD_TERM);
	wire is_act   = (req_r.cmd == SRB_CMD_ACT);

	wire [8:0] burst_cnt = (bl_r == BL_ONE)   ? 9'h001 :
	                       (bl_r == BL_TWO)   ? 9'h002 :
	                       (bl_r == BL_FOUR)  ? 9'h004 :
	                       (bl_r == BL_EIGHT) ? 9'h008 : 9'h000;
	wire       page_mode = (bl_r == BL_PAGE);

	// ----------------------------------------
	// Burst engine (array address side)
	// ----------------------------------------
	srb_state_t          st_r;
	srb_state_t          st_nxt;
	logic [BANK_W-1:0]   bank_r;
	logic [COL_W-1:0]    col_r;
	logic [COL_W-1:0]    col_nxt;
	logic [8:0]          left_r;
	logic [8:0]          left_nxt;
	logic                ap_r;
	logic                page_r;
	logic                last_beat;
	logic                ap_close;

	// Element issued this cycle reaches pins after the latency pipe
	wire issue     = is_read || (st_r == SRB_RUN);
	wire stop_now  = is_term || is_write || (is_pre && req_r.bank == bank_r) || (is_pre && req_r.all_banks);

	always_comb begin
		st_nxt    = st_r;
		col_nxt   = col_r;
		left_nxt  = left_r;
		last_beat = 1'b0;
		ap_close  = 1'b0;
		if (is_read) begin
			// Fresh burst replaces any running one
			col_nxt  = req_r.col + 8'h01;
			left_nxt = burst_cnt - 9'h001;
			st_nxt   = (page_mode || burst_cnt != 9'h001) ? SRB_RUN : SRB_IDLE;
			last_beat = !page_mode && (burst_cnt == 9'h001);
			ap_close  = last_beat && req_r.auto_pre;
		end else if (st_r == SRB_RUN) begin
			if (stop_now) begin
				st_nxt = SRB_IDLE;
			end else begin
				col_nxt = col_r + 8'h01;
				if (!page_r) begin
					left_nxt = left_r - 9'h001;
					if (left_r == 9'h001) begin
						st_nxt    = SRB_IDLE;
						last_beat = 1'b1;
						ap_close  = ap_r;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r   <= SRB_IDLE;
			col_r  <= '0;
			left_r <= '0;
			bank_r <= '0;
			ap_r   <= 1'b0;
			page_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			col_r  <= col_nxt;
			left_r <= left_nxt;
			if (is_read) begin
				bank_r <= req_r.bank;
				ap_r   <= req_r.auto_pre;
				page_r <= page_mode;
			end
		end
	end

	// ----------------------------------------
	// Array address outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arr_bank <= '0;
			arr_col  <= '0;
		end else begin
			arr_bank <= is_read ? req_r.bank : bank_r;
			arr_col  <= is_read ? req_r.col : col_r;
		end
	end

	// ----------------------------------------
	// Latency pipe (valid, mask)
	// ----------------------------------------
	logic [LAT_MAX-1:0] vld_pipe_r;
	logic [1:0]         mask_pipe_r;
	logic               wr_kill_r;
	logic [DATA_W-1:0]  dat1_r;
	logic [DATA_W-1:0]  dat2_r;

	// Entry 0 is one cycle after issue, array data arrives aligned there
	wire vld_issue = issue && !(st_r == SRB_RUN && stop_now && !is_read);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vld_pipe_r  <= '0;
			mask_pipe_r <= '0;
			wr_kill_r   <= 1'b0;
			dat1_r      <= '0;
			dat2_r      <= '0;
		end else begin
			vld_pipe_r  <= {vld_pipe_r[LAT_MAX-2:0], vld_issue};
			// Data rides beside its valid bit so both leave at the same tap
			dat1_r      <= arr_data;
			dat2_r      <= dat1_r;
			mask_pipe_r <= {mask_pipe_r[0], mask_r};
			// Truncating write parks the pins; mask high just before it is required
			if (is_write)
				wr_kill_r <= 1'b1;
			else if (is_read)
				wr_kill_r <= 1'b0;
		end
	end

	// Stops act at issue; elements already in the pipe still reach the pins unless the stop is a write
	wire out_vld = (cl_r == 2'h2) ? vld_pipe_r[1] : vld_pipe_r[2];
	wire [DATA_W-1:0] out_dat = (cl_r == 2'h2) ? dat1_r : dat2_r;

	// ----------------------------------------
	// Data output
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dq_out <= '0;
			dq_oe  <= 1'b0;
		end else begin
			dq_out <= out_dat;
			// Output masking lags the sampled mask by two clocks
			dq_oe  <= out_vld && !mask_pipe_r[1] && !(wr_kill_r || is_write);
		end
	end

	// ----------------------------------------
	// Open-row tracking per bank
	// ----------------------------------------
	logic [NBANK-1:0] open_r;

	genvar gb;
	generate
		for (gb = 0; gb < NBANK; gb++) begin : g_bank
			wire hit      = (req_r.bank == BANK_W'(gb));
			wire pre_hit  = is_pre && (hit || req_r.all_banks);
			wire ap_hit   = ap_close && (is_read ? hit : (bank_r == BANK_W'(gb)));
			always_ff @(posedge clk) begin
				if (sys_rst)
					open_r[gb] <= 1'b0;
				else if (pre_hit || ap_hit)
					open_r[gb] <= 1'b0;
				else if (is_act && hit)
					open_r[gb] <= 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst)
			row_open <= '0;
		else
			row_open <= open_r;
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	wire [31:0] rd_mux = (reg_addr == REG_MODE_OFS)   ? {26'h0, cl_r, 1'b0, bl_r} :
	                     (reg_addr == REG_STATUS_OFS) ? {30'h0, dq_oe, st_r == SRB_RUN} :
	                     (reg_addr == REG_ROWS_OFS)   ? {28'h0, open_r} : 32'h0;

	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_read_cl3;
		is_read && cl_r == 2'h3 && !mask_r && !is_write;
	endsequence

	AST_FIRST_LATENCY: assert property (@(posedge clk) disable iff (sys_rst)
		s_read_cl3 ##1 (!is_write && !mask_r && cl_r == 2'h3)[*3] |=> dq_oe)
		else $error("read data not presented at latency");

	AST_NO_OE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
		(vld_pipe_r == '0 && !issue)[*2] |=> !dq_oe)
		else $error("pins driven with no burst pending");

	AST_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r == SRB_RUN && page_r && !stop_now && !is_read && col_r == 8'hFF) |=> col_r == 8'h00)
		else $error("page column did not wrap");

	AST_BACK_TO_BACK: assert property (@(posedge clk) disable iff (sys_rst)
		is_read |=> vld_pipe_r[0])
		else $error("read not accepted");

	AST_WRITE_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
		is_write |=> !dq_oe)
		else $error("pins driven after truncating write");

	AST_AUTO_CLOSE: assert property (@(posedge clk) disable iff (sys_rst)
		(ap_close && !is_read && !is_act) |=> !open_r[bank_r])
		else $error("auto precharge did not close row");

	AST_TERM_KEEPS_ROW: assert property (@(posedge clk) disable iff (sys_rst)
		(is_term && open_r[bank_r] && !ap_close) |=> open_r[$past(bank_r)])
		else $error("terminate closed the row");

	AST_BL_LEN: assert property (@(posedge clk) disable iff (sys_rst)
		(is_read && bl_r == BL_FOUR) ##1 (!is_read && !stop_now)[*3] |=> st_r == SRB_IDLE)
		else $error("burst of four did not end");

endmodule

`default_nettype wire

// File: srb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module srb_ctl_model
	import srb_pkg::*;
#(
	parameter int RCD                = 3,
	parameter int ROW_PRECHARGE_TIME = 3
)(
	// Clock
	input  wire logic              clk,
	// Pins toward the device
	output srb_req_t               req_pin,
	output logic                   out_mask_pin,
	// Array behind the device
	input  wire logic [BANK_W-1:0] arr_bank,
	input  wire logic [COL_W-1:0]  arr_col,
	output logic [DATA_W-1:0]      arr_data
);
	// Array content follows its own address
	assign arr_data = {arr_bank, 6'h15, arr_col};

	initial begin
		req_pin = '0;
		out_mask_pin = 1'b0;
	end

	// One command per edge; the caller sends a no-op to end
	task automatic cmd(input srb_cmd_t c, input logic [1:0] b, input logic [7:0] col,
		input logic ap);
		@(posedge clk);
		req_pin <= '{c, b, col, ap, 1'b0};
	endtask

	task automatic open_row(input logic [1:0] b);
		cmd(SRB_CMD_ACT, b, 8'h00, 1'b0);
		cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
		repeat (RCD) @(posedge clk);
	endtask

	// Mask high for two clocks, then low with the write
	task automatic trunc_write(input logic [1:0] b);
		@(posedge clk);
		out_mask_pin <= 1'b1;
		req_pin <= '{SRB_CMD_NOP, b, 8'h00, 1'b0, 1'b0};
		repeat (2) @(posedge clk);
		out_mask_pin <= 1'b0;
		req_pin <= '{SRB_CMD_WRITE, b, 8'h00, 1'b0, 1'b0};
	endtask

	// Nothing goes to a closed bank until the precharge time has run out
	task automatic wait_precharge();
		repeat (ROW_PRECHARGE_TIME) @(posedge clk);
	endtask

	task automatic close_all();
		@(posedge clk);
		req_pin <= '{SRB_CMD_PRE, 2'h0, 8'h00, 1'b0, 1'b1};
	endtask
endmodule

`default_nettype wire

// File: sdram_read_burst_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_read_burst_control_tb_top
	import srb_pkg::*;
;
	typedef struct packed {
		logic [2:0] bl;
		logic [1:0] cl;
		logic [7:0] col;
		logic [7:0] n;
	} srb_row_t;

	logic clk, sys_rst, out_mask_pin, dq_oe, reg_wr, reg_rd;
	srb_req_t req_pin;
	logic [DATA_W-1:0] dq_out, arr_data;
	logic [BANK_W-1:0] arr_bank;
	logic [COL_W-1:0] arr_col;
	logic [3:0] reg_addr, row_open;
	logic [31:0] reg_wdata, reg_rdata;
	int error_cnt = 0;
	int n_compared = 0;
	srb_row_t rows [5] = '{
		'{BL_ONE, 2'h3, 8'h10, 8'h01}, '{BL_TWO, 2'h2, 8'h20, 8'h02},
		'{BL_FOUR, 2'h3, 8'h30, 8'h04}, '{BL_EIGHT, 2'h2, 8'h40, 8'h08},
		'{BL_EIGHT, 2'h3, 8'h50, 8'h08}};

	srb_read_burst dut (.clk(clk), .sys_rst(sys_rst), .req_pin(req_pin),
		.out_mask_pin(out_mask_pin), .dq_out(dq_out), .dq_oe(dq_oe), .arr_bank(arr_bank),
		.arr_col(arr_col), .arr_data(arr_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .row_open(row_open));
	srb_ctl_model u_ctl (.clk(clk), .req_pin(req_pin), .out_mask_pin(out_mask_pin),
		.arr_bank(arr_bank), .arr_col(arr_col), .arr_data(arr_data));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask

	// Elements of the first burst (na of them) then of the second, no gaps
	task automatic collect(input logic [1:0] bk, input logic [7:0] a, input int na,
		input logic [7:0] b, input int n, input int first);
		int k, f, l;
		logic [7:0] c;
		k = 0; f = 0; l = 0;
		for (int j = 1; j <= 40; j++) begin
			@(negedge clk);
			if (dq_oe === 1'b1) begin
				if (k == 0) f = j;
				l = j;
				c = (k < na) ? a + 8'(k) : b + 8'(k - na);
				chk(32'(dq_out), {16'h0, bk, 6'h15, c});
				k++;
			end
		end
		chk(k, n);
		chk(f, first);
		chk(l - f + 1, n);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim();
	end

	initial begin
		sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rd(REG_MODE_OFS, 32'h32);
		rd(4'hF, 32'h0);
		rd(REG_STATUS_OFS, 32'h0);
		for (int i = 0; i < 4; i++) u_ctl.open_row(2'(i));
		rd(REG_ROWS_OFS, 32'hF);
		foreach (rows[i]) begin
			wr(REG_MODE_OFS, {26'h0, rows[i].cl, 1'b0, rows[i].bl});
			rd(REG_MODE_OFS, {26'h0, rows[i].cl, 1'b0, rows[i].bl});
			u_ctl.cmd(SRB_CMD_READ, 2'h1, rows[i].col, 1'b0);
			fork
				collect(2'h1, 8'h0, 0, rows[i].col, rows[i].n, rows[i].cl + 4);
				u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
			join
			chk(dq_oe, 1'b0);
			$display("row %0d done", i);
		end
		// Back-to-back reads: one element of the first, then the second burst
		wr(REG_MODE_OFS, 32'h32);
		u_ctl.cmd(SRB_CMD_READ, 2'h0, 8'h60, 1'b0);
		u_ctl.cmd(SRB_CMD_READ, 2'h0, 8'h80, 1'b0);
		fork
			collect(2'h0, 8'h60, 1, 8'h80, 5, 6);
			u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
		join
		$display("chained reads done");
		// Full page across the wrap, stopped by terminate
		wr(REG_MODE_OFS, {26'h0, 2'h3, 1'b0, BL_PAGE});
		u_ctl.cmd(SRB_CMD_READ, 2'h3, 8'hFE, 1'b0);
		fork
			collect(2'h3, 8'h0, 0, 8'hFE, 6, 7);
			begin
				repeat (5) u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_TERM, 2'h3, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
			end
		join
		chk(row_open, 4'hF);
		$display("page terminate done");
		// Page read cut by a row close to its bank; bank reopened afterwards
		u_ctl.cmd(SRB_CMD_READ, 2'h1, 8'h10, 1'b0);
		fork
			collect(2'h1, 8'h0, 0, 8'h10, 4, 7);
			begin
				repeat (3) u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_PRE, 2'h1, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
			end
		join
		chk(row_open, 4'hD);
		u_ctl.wait_precharge();
		u_ctl.open_row(2'h1);
		rd(REG_ROWS_OFS, 32'hF);
		$display("page close done");
		// Page read cut by a masked write; pins stay released after it
		u_ctl.cmd(SRB_CMD_READ, 2'h0, 8'h00, 1'b0);
		fork
			collect(2'h0, 8'h0, 0, 8'h00, 4, 7);
			begin
				repeat (4) u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
				u_ctl.trunc_write(2'h0);
				u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
			end
		join
		chk(dq_oe, 1'b0);
		$display("write truncation done");
		// Single-element burst followed by an unmasked write
		wr(REG_MODE_OFS, {26'h0, 2'h3, 1'b0, BL_ONE});
		u_ctl.cmd(SRB_CMD_READ, 2'h1, 8'h90, 1'b0);
		fork
			collect(2'h1, 8'h0, 0, 8'h90, 1, 7);
			begin
				repeat (3) u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_WRITE, 2'h1, 8'h00, 1'b0);
				u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
			end
		join
		$display("single then write done");
		// Auto-precharge burst closes its row afterwards
		wr(REG_MODE_OFS, 32'h32);
		u_ctl.cmd(SRB_CMD_READ, 2'h2, 8'h70, 1'b1);
		fork
			collect(2'h2, 8'h0, 0, 8'h70, 4, 7);
			u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
		join
		chk(row_open, 4'hB);
		$display("auto close done");
		// Close every bank at once
		u_ctl.close_all();
		u_ctl.cmd(SRB_CMD_NOP, 2'h0, 8'h00, 1'b0);
		repeat (2) @(posedge clk);
		rd(REG_ROWS_OFS, 32'h0);
		$display("close all done");
		end_sim();
	end
endmodule

`default_nettype wire
